// ==== hdl/tkds_top.v ====
// touch key detection, drift, recalibration, slider and burst sequencing
`timescale 1ns/1ns
`include "tkds_defs.vh"
module tkds_top #(
  parameter TICK_CYCLES = `TKDS_TICK_CYCLES,
  parameter NKEYS       = 16
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  // setup byte port, written and read by the serial slave front end
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  input  wire        host_recal,
  input  wire [4:0]  detect_filter_limit,
  // acquisition results from the charge front end, one key at a time
  input  wire        acq_valid,
  input  wire [3:0]  acq_key,
  input  wire [15:0] acq_signal,
  input  wire        acq_drift_step,
  input  wire        acq_drift_up,
  input  wire        scan_done,
  // burst request and pulse lines
  input  wire        burst_start,
  input  wire [3:0]  burst_key,
  output reg  [7:0]  drive_line,
  output reg  [1:0]  receive_enable,
  output reg         burst_busy,
  // results
  output reg  [15:0] key_detect,
  output reg  [7:0]  slider_position,
  output reg         slider_touched,
  output reg         sleep_request,
  output reg         use_min_interval,
  output reg         drift_frozen
);
  // ==========================================================================
  // setup registers
  reg [7:0] detect_recal_delay;
  reg [7:0] drift_freeze_time;
  reg [7:0] slider_control;
  reg [7:0] slider_options;
  reg [1:0] suppression_group [0:NKEYS-1];
  reg [7:0] touch_threshold   [0:NKEYS-1];
  reg [7:0] burst_length      [0:NKEYS-1];
  integer   i;
  integer   bi;
  integer   di;
  integer   si;

  function in_range;
    input [7:0] a;
    input [7:0] base;
    begin
      in_range = (a >= base) && (a < base + 8'h10);
    end
  endfunction

  wire [3:0] cfg_idx = cfg_addr[3:0] - 4'h6;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      detect_recal_delay <= `TKDS_RST_RECAL;
      drift_freeze_time  <= `TKDS_RST_FREEZE;
      slider_control     <= `TKDS_RST_SLD_CTRL;
      slider_options     <= `TKDS_RST_SLD_OPT;
      for (i = 0; i < NKEYS; i = i + 1) begin
        suppression_group[i] <= 2'h0;
        touch_threshold[i]   <= `TKDS_RST_THRESH;
        burst_length[i]      <= `TKDS_RST_BURST;
      end
    end else if (cfg_wr) begin
      if (cfg_addr == `TKDS_ADDR_RECAL) begin
        detect_recal_delay <= cfg_wdata;
      end
      if (cfg_addr == `TKDS_ADDR_FREEZE) begin
        drift_freeze_time <= cfg_wdata;
      end
      if (cfg_addr == `TKDS_ADDR_SLD_CTRL) begin
        slider_control <= cfg_wdata;
      end
      if (cfg_addr == `TKDS_ADDR_SLD_OPT) begin
        slider_options <= {5'h00, cfg_wdata[2:0]};
      end
      if (in_range(cfg_addr, `TKDS_ADDR_KEY_CTRL)) begin
        suppression_group[cfg_idx] <= cfg_wdata[1:0];
      end
      if (in_range(cfg_addr, `TKDS_ADDR_THRESH)) begin
        touch_threshold[cfg_idx] <= cfg_wdata;
      end
      if (in_range(cfg_addr, `TKDS_ADDR_BURST)) begin
        burst_length[cfg_idx] <= cfg_wdata;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_addr == `TKDS_ADDR_RECAL) begin
      cfg_rdata <= detect_recal_delay;
    end else if (cfg_addr == `TKDS_ADDR_FREEZE) begin
      cfg_rdata <= drift_freeze_time;
    end else if (cfg_addr == `TKDS_ADDR_SLD_CTRL) begin
      cfg_rdata <= slider_control;
    end else if (cfg_addr == `TKDS_ADDR_SLD_OPT) begin
      cfg_rdata <= slider_options;
    end else if (in_range(cfg_addr, `TKDS_ADDR_KEY_CTRL)) begin
      cfg_rdata <= {6'h00, suppression_group[cfg_idx]};
    end else if (in_range(cfg_addr, `TKDS_ADDR_THRESH)) begin
      cfg_rdata <= touch_threshold[cfg_idx];
    end else if (in_range(cfg_addr, `TKDS_ADDR_BURST)) begin
      cfg_rdata <= burst_length[cfg_idx];
    end else begin
      cfg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // 0.16 s tick
  reg [31:0] tick_cnt;
  reg        tick;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // ==========================================================================
  // reference store; the reference is read one cycle after the acquisition
  reg         acq_v1;
  reg  [3:0]  acq_k1;
  reg  [15:0] acq_s1;
  reg         acq_step1;
  reg         acq_up1;
  wire [15:0] ref_level;
  reg         ref_wr;
  reg  [15:0] ref_wdata;
  reg  [3:0]  ref_waddr;

  tkds_key_mem #(.WIDTH(16), .DEPTH(NKEYS), .AW(4)) u_ref (
    .sys_clk (sys_clk),
    .wr_en   (ref_wr),
    .wr_addr (ref_waddr),
    .wr_data (ref_wdata),
    .rd_addr (acq_key),
    .rd_data (ref_level)
  );

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_v1    <= 1'b0;
      acq_k1    <= 4'h0;
      acq_s1    <= 16'h0;
      acq_step1 <= 1'b0;
      acq_up1   <= 1'b0;
    end else begin
      acq_v1    <= acq_valid;
      acq_k1    <= acq_key;
      acq_s1    <= acq_signal;
      acq_step1 <= acq_drift_step;
      acq_up1   <= acq_drift_up;
    end
  end

  // ==========================================================================
  // detection, integrator, recalibration, drift
  reg  [4:0] integ      [0:NKEYS-1];
  reg  [7:0] detect_age [0:NKEYS-1];
  reg  [15:0] recal_pend;
  reg  [7:0] freeze_cnt;
  reg  [7:0] awake_cnt;
  reg        state_change;

  // level is recomputed from the live reference on every acquisition
  wire [15:0] thr16     = {8'h00, touch_threshold[acq_k1]};
  wire [15:0] diff      = (ref_level > acq_s1) ? (ref_level - acq_s1) : 16'h0;
  wire        below_thr = diff > thr16;
  wire        above_rel = diff > (thr16 - `TKDS_RELEASE_MARGIN);
  wire        key_off   = (burst_length[acq_k1] == 8'h00);
  wire [3:0]  sld_keys  = slider_control[`TKDS_SLD_KEYS_MSB:`TKDS_SLD_KEYS_LSB];
  wire        pass_limit = integ[acq_k1] >= detect_filter_limit;

  // first receive line keys 0..7, slider starts at the first drive line
  function is_slider;
    input [3:0] k;
    input [3:0] n;
    begin
      is_slider = (k[3] == 1'b0) && ({1'b0, k[2:0]} < n);
    end
  endfunction

  reg blocked;
  always @* begin
    blocked = 1'b0;
    for (bi = 0; bi < NKEYS; bi = bi + 1) begin
      if (key_detect[bi] && (bi != acq_k1) && (suppression_group[acq_k1] != 2'h0)
          && (suppression_group[bi] == suppression_group[acq_k1])
          && !(is_slider(bi[3:0], sld_keys) && is_slider(acq_k1, sld_keys))) begin
        blocked = 1'b1;
      end
    end
  end

  always @* begin
    ref_wr    = 1'b0;
    ref_waddr = acq_k1;
    ref_wdata = ref_level;
    if (acq_v1) begin
      if (recal_pend[acq_k1]) begin
        ref_wr    = 1'b1;
        ref_wdata = acq_s1;
      end else if (acq_step1 && !key_detect[acq_k1] && !below_thr
                   && freeze_cnt == 8'h00) begin
        ref_wr    = 1'b1;
        ref_wdata = acq_up1 ? ref_level + 16'h1 : ref_level - 16'h1;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_detect   <= 16'h0;
      recal_pend   <= 16'h0;
      state_change <= 1'b0;
      for (di = 0; di < NKEYS; di = di + 1) begin
        integ[di]      <= 5'h0;
        detect_age[di] <= 8'h0;
      end
    end else begin
      state_change <= 1'b0;
      for (di = 0; di < NKEYS; di = di + 1) begin
        if (host_recal) begin
          recal_pend[di] <= 1'b1;
        end
        if (key_detect[di] && tick) begin
          if (detect_recal_delay != 8'h00 && detect_age[di] + 8'h1 >= detect_recal_delay) begin
            recal_pend[di] <= 1'b1;
          end
          if (detect_age[di] != 8'hff) begin
            detect_age[di] <= detect_age[di] + 8'h1;
          end
        end
      end
      if (acq_v1) begin
        if (recal_pend[acq_k1] || key_off) begin
          if (!host_recal) begin
            recal_pend[acq_k1] <= 1'b0;
          end
          integ[acq_k1]      <= 5'h0;
          detect_age[acq_k1] <= 8'h0;
          if (key_detect[acq_k1]) begin
            state_change <= 1'b1;
          end
          key_detect[acq_k1] <= 1'b0;
        end else if (key_detect[acq_k1]) begin
          if (!above_rel) begin
            key_detect[acq_k1] <= 1'b0;
            detect_age[acq_k1] <= 8'h0;
            state_change       <= 1'b1;
          end
        end else if (!below_thr || blocked) begin
          integ[acq_k1] <= 5'h0;
        end else if (pass_limit) begin
          key_detect[acq_k1] <= 1'b1;
          integ[acq_k1]      <= 5'h0;
          detect_age[acq_k1] <= 8'h0;
          state_change       <= 1'b1;
        end else begin
          integ[acq_k1] <= integ[acq_k1] + 5'h1;
        end
      end
    end
  end

  // ==========================================================================
  // drift freeze and awake timing share one setting
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_cnt       <= 8'h0;
      awake_cnt        <= 8'h0;
      drift_frozen     <= 1'b0;
      use_min_interval <= 1'b0;
      sleep_request    <= 1'b0;
    end else begin
      if (key_detect != 16'h0) begin
        freeze_cnt <= drift_freeze_time;
      end else if (tick && freeze_cnt != 8'h00) begin
        freeze_cnt <= freeze_cnt - 8'h1;
      end
      if (state_change) begin
        awake_cnt <= drift_freeze_time;
      end else if (tick && awake_cnt != 8'h00) begin
        awake_cnt <= awake_cnt - 8'h1;
      end
      drift_frozen     <= (freeze_cnt != 8'h00);
      use_min_interval <= (awake_cnt != 8'h00) || state_change;
      sleep_request    <= scan_done && !state_change;
    end
  end

  // ==========================================================================
  // slider: position of the lowest detected slider key on 8-bit scale, backlash, then scaling
  wire [3:0] sld_back = slider_control[`TKDS_SLD_BACK_MSB:`TKDS_SLD_BACK_LSB];
  wire [2:0] sld_res  = slider_options[`TKDS_SLD_RES_MSB:`TKDS_SLD_RES_LSB];
  reg  [7:0] raw_pos;
  reg  [3:0] first_hit;
  reg        any_hit;
  reg [11:0] pos_num;
  reg [11:0] pos_quot;
  always @* begin
    first_hit = 4'h0;
    any_hit   = 1'b0;
    pos_quot  = 12'h000;
    for (si = 7; si >= 0; si = si - 1) begin
      if (key_detect[si] && is_slider(si[3:0], sld_keys)) begin
        first_hit = si[3:0];
        any_hit   = 1'b1;
      end
    end
    // key index times 255 over keys minus one puts the last slider key at full scale, so no clipping is needed
    pos_num = {first_hit, 8'h00} - {8'h00, first_hit};
    if (sld_keys > 4'h1) begin
      pos_quot = pos_num / {8'h00, sld_keys - 4'h1};
    end
    raw_pos = pos_quot[7:0];
  end

  reg [7:0] held_pos;
  reg       dir_up;
  reg       first_move;
  wire [8:0] back_n = {5'h00, sld_back} + 9'h001;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_pos        <= 8'h00;
      dir_up          <= 1'b1;
      first_move      <= 1'b1;
      slider_touched  <= 1'b0;
      slider_position <= 8'h00;
    end else begin
      slider_touched <= any_hit && (sld_keys != 4'h0);
      if (!any_hit || sld_keys == 4'h0) begin
        first_move <= 1'b1;
      end else if (first_move) begin
        held_pos   <= raw_pos;
        first_move <= (raw_pos == held_pos);
      end else if (raw_pos > held_pos) begin
        if (dir_up || {1'b0, raw_pos} >= {1'b0, held_pos} + back_n) begin
          held_pos <= raw_pos;
          dir_up   <= 1'b1;
        end
      end else if (raw_pos < held_pos) begin
        if (!dir_up || {1'b0, raw_pos} + back_n <= {1'b0, held_pos}) begin
          held_pos <= raw_pos;
          dir_up   <= 1'b0;
        end
      end
      slider_position <= held_pos >> (sld_res > 3'h6 ? 3'h6 : sld_res);
    end
  end

  // ==========================================================================
  // burst: four pulses per length unit on the key's drive line
  reg [9:0] pulse_left;
  reg [3:0] bkey;
  reg       phase;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_left     <= 10'h000;
      bkey           <= 4'h0;
      phase          <= 1'b0;
      burst_busy     <= 1'b0;
      drive_line     <= 8'h00;
      receive_enable <= 2'h0;
    end else if (!burst_busy) begin
      drive_line     <= 8'h00;
      receive_enable <= 2'h0;
      phase          <= 1'b0;
      if (burst_start && burst_length[burst_key] != 8'h00) begin
        pulse_left <= {burst_length[burst_key], 2'b00};
        bkey       <= burst_key;
        burst_busy <= 1'b1;
      end
    end else begin
      receive_enable <= 2'h1 << bkey[3];
      phase          <= ~phase;
      if (!phase) begin
        drive_line <= 8'h01 << bkey[2:0];
      end else begin
        drive_line <= 8'h00;
        pulse_left <= pulse_left - 10'h001;
        if (pulse_left == 10'h001) begin
          burst_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== hdl/tkds_defs.vh ====
// constants for the touch key detection setup block
// ==========================================================================
`ifndef TKDS_DEFS_VH
`define TKDS_DEFS_VH

`define TKDS_ADDR_RECAL        8'h12
`define TKDS_ADDR_FREEZE       8'h13
`define TKDS_ADDR_SLD_CTRL     8'h14
`define TKDS_ADDR_SLD_OPT      8'h15
`define TKDS_ADDR_KEY_CTRL     8'h16
`define TKDS_ADDR_THRESH       8'h26
`define TKDS_ADDR_BURST        8'h36
`define TKDS_ADDR_END          8'h46

`define TKDS_RST_RECAL         8'hff
`define TKDS_RST_FREEZE        8'h19
`define TKDS_RST_SLD_CTRL      8'h05
`define TKDS_RST_SLD_OPT       8'h04
`define TKDS_RST_KEY_CTRL      8'h00
`define TKDS_RST_THRESH        8'h0a
`define TKDS_RST_BURST         8'h04

// slider control: backlash in high nibble, key count in low nibble; slider options: resolution in bits 2..0
`define TKDS_SLD_BACK_MSB      7
`define TKDS_SLD_BACK_LSB      4
`define TKDS_SLD_KEYS_MSB      3
`define TKDS_SLD_KEYS_LSB      0
`define TKDS_SLD_RES_MSB       2
`define TKDS_SLD_RES_LSB       0

`define TKDS_RELEASE_MARGIN    16'h0002
`define TKDS_TICK_NS           160000000
`define TKDS_CLK_NS            20
`define TKDS_TICK_CYCLES       (`TKDS_TICK_NS / `TKDS_CLK_NS)

`endif

// ==== hdl/tkds_key_mem.v ====
// per-key word store with registered read data
`timescale 1ns/1ns
module tkds_key_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== testbench/tkds_checker_properties.sv ====
// port-level checks for the touch key detection setup block
`timescale 1ns/1ns
module tkds_checker (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        cfg_wr,
  input wire [7:0]  cfg_addr,
  input wire [7:0]  cfg_wdata,
  input wire [7:0]  cfg_rdata,
  input wire        scan_done,
  input wire        burst_start,
  input wire [7:0]  drive_line,
  input wire [1:0]  receive_enable,
  input wire        burst_busy,
  input wire [15:0] key_detect,
  input wire        sleep_request,
  input wire        use_min_interval,
  input wire        drift_frozen
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_pulse_one_cycle: assert property (drive_line != 8'h00 |=> drive_line == 8'h00)
    else $error("drive pulse held longer than one cycle");
  a_drive_onehot: assert property (drive_line != 8'h00 |->
    burst_busy && $onehot(drive_line) && $onehot(receive_enable))
    else $error("drive pulse outside a burst or not one-hot");
  a_idle_no_drive: assert property (!burst_busy |-> drive_line == 8'h00)
    else $error("drive line active while no burst runs");
  a_busy_cause: assert property ($rose(burst_busy) |-> $past(burst_start) || $past(burst_start, 2))
    else $error("burst started without a request");
  a_sleep_cause: assert property (sleep_request |-> $past(scan_done))
    else $error("sleep request without a finished scan");
  a_sleep_pulse: assert property (sleep_request && !scan_done |=> !sleep_request)
    else $error("sleep request longer than one cycle");
  a_awake_follows: assert property ($changed(key_detect) |-> ##[0:2] use_min_interval)
    else $error("key change did not start the awake timer");
  a_freeze_detect: assert property (key_detect != 16'h0000 |-> ##[0:2] drift_frozen)
    else $error("drift not frozen while a key is detected");
  a_cfg_readback: assert property ((cfg_wr && (cfg_addr == 8'h12 ||
    cfg_addr == 8'h13 || (cfg_addr >= 8'h26 && cfg_addr <= 8'h45)))
    ##1 (!cfg_wr && $stable(cfg_addr)) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("setup byte read back differs from write");

  c_burst: cover property ($rose(burst_busy));
  c_sleep: cover property (sleep_request);
  c_touch: cover property ($rose(key_detect[9]));
  c_release: cover property ($fell(key_detect[9]));
endmodule

bind tkds_top tkds_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scan_done(scan_done),
  .burst_start(burst_start), .drive_line(drive_line), .receive_enable(receive_enable),
  .burst_busy(burst_busy), .key_detect(key_detect), .sleep_request(sleep_request),
  .use_min_interval(use_min_interval), .drift_frozen(drift_frozen));

// ==== testbench/tkds_host_model.sv ====
// host model that writes and reads the setup bytes
`timescale 1ns/1ns
module tkds_host_model (
  input  wire       sys_clk,
  input  wire [7:0] cfg_rdata,
  output reg        cfg_wr,
  output reg  [7:0] cfg_addr,
  output reg  [7:0] cfg_wdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end

  // ==========================================================
  // bus tasks, entered just after a rising edge
  // the host never hands over a value the device treats as invalid
  task wr(input logic [7:0] a, input logic [7:0] dat);
    logic [7:0] v;
    begin
      v = dat;
      if (a == 8'h13 && v < 8'h02) v = 8'h02;
      if (a == 8'h14 && (v[3:0] == 4'h1 || v[3:0] > 4'h8)) v[3:0] = 4'h2;
      cfg_addr = a;
      cfg_wdata = v;
      cfg_wr = 1'b1;
      @(posedge sys_clk);
      #1 cfg_wr = 1'b0;
      // released data does not keep its last value
      cfg_wdata = ~v;
      @(posedge sys_clk);
      #1;
    end
  endtask

  task rd(input logic [7:0] a, output logic [7:0] dat);
    begin
      cfg_addr = a;
      @(posedge sys_clk);
      @(posedge sys_clk);
      #1 dat = cfg_rdata;
    end
  endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the touch key detection setup block
`timescale 1ns/1ns
module tb;
  localparam int K = 9;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_recal = 1'b0;
  logic        acq_valid = 1'b0;
  logic [3:0]  acq_key = 4'h0;
  logic [15:0] acq_signal = 16'h0000;
  logic        scan_done = 1'b0;
  logic        burst_start = 1'b0;
  logic [3:0]  burst_key = 4'h0;
  wire         cfg_wr;
  wire  [7:0]  cfg_addr;
  wire  [7:0]  cfg_wdata;
  wire  [7:0]  cfg_rdata;
  wire  [7:0]  drive_line;
  wire  [7:0]  slider_position;
  wire  [1:0]  receive_enable;
  wire  [15:0] key_detect;
  wire         burst_busy;
  wire         slider_touched;
  wire         sleep_request;
  wire         use_min_interval;
  wire         drift_frozen;
  int          failures = 0;
  int          comparisons = 0;
  int          ref_lvl [16];
  int          integ [16];
  bit          det [16];
  bit          pend [16];
  int          th;
  logic [4:0]  dil = 5'h01;
  int          grp [16];
  int          len;
  int          bk;
  logic [7:0]  d;
  logic [7:0]  addrs [$] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h25, 8'h26, 8'h35,
                             8'h36, 8'h45, 8'h11, 8'h50};
  logic [7:0]  rstv [$] = '{8'hff, 8'h19, 8'h05, 8'h04, 8'h00, 8'h00, 8'h0a, 8'h0a,
                            8'h04, 8'h04, 8'h00, 8'h00};
  logic [7:0]  wa [4] = '{8'h12, 8'h15, 8'h2a, 8'h3f};
  logic [7:0]  wm [4] = '{8'hff, 8'h07, 8'hff, 8'hff};

  tkds_top #(.TICK_CYCLES(10), .NKEYS(16)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .host_recal(host_recal),
    .detect_filter_limit(dil), .acq_valid(acq_valid), .acq_key(acq_key),
    .acq_signal(acq_signal), .acq_drift_step(1'b0), .acq_drift_up(1'b0),
    .scan_done(scan_done), .burst_start(burst_start), .burst_key(burst_key),
    .drive_line(drive_line), .receive_enable(receive_enable), .burst_busy(burst_busy),
    .key_detect(key_detect), .slider_position(slider_position),
    .slider_touched(slider_touched), .sleep_request(sleep_request),
    .use_min_interval(use_min_interval), .drift_frozen(drift_frozen));

  tkds_host_model host_u (.sys_clk(sys_clk), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));

  always #10 sys_clk = ~sys_clk;

  // ==========================================================
  // checking helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      comparisons++;
      if (got !== exp) begin
        failures++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] e);
    begin
      host_u.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
    end
  endtask

  // reference model of one key's detection, then one acquisition on the design
  task acq(input int k, input int sig);
    int diff;
    bit blk;
    begin
      diff = ref_lvl[k] - sig;
      blk = 1'b0;
      for (int j = 0; j < 16; j++)
        if (det[j] && j != k && grp[k] != 0 && grp[j] == grp[k]
            && !(j < 5 && k < 5))
          blk = 1'b1;
      if (pend[k]) begin
        ref_lvl[k] = sig;
        det[k] = 1'b0;
        integ[k] = 0;
        pend[k] = 1'b0;
      end else if (!det[k]) begin
        integ[k] = (diff > th && !blk) ? integ[k] + 1 : 0;
        det[k] = integ[k] >= dil + 1;
      end else if (diff <= th - 2) begin
        det[k] = 1'b0;
        integ[k] = 0;
      end
      acq_key = k[3:0];
      acq_signal = sig[15:0];
      acq_valid = 1'b1;
      @(posedge sys_clk);
      #1 acq_valid = 1'b0;
      @(posedge sys_clk);
      #1 chk({15'h0000, key_detect[k]}, {15'h0000, det[k]});
    end
  endtask

  task burst(input int k, input int n4);
    int p;
    begin
      p = 0;
      burst_key = k[3:0];
      burst_start = 1'b1;
      @(posedge sys_clk);
      #1 burst_start = 1'b0;
      for (int n = 0; n < 4000; n++) begin
        if (drive_line !== 8'h00) begin
          p++;
          chk({8'h00, drive_line}, 16'h0001 << k[2:0]);
          chk({14'h0000, receive_enable}, 16'h0001 << k[3]);
        end
        if (n > 2 && burst_busy !== 1'b1) break;
        @(posedge sys_clk);
        #1;
      end
      chk(p[15:0], 16'(4 * n4));
    end
  endtask

  task conclude;
    begin
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(44));
    th = 6 + ($urandom % 10);
    dil = 5'(1 + $urandom % 3);
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    host_u.wr(8'h50, 8'ha5);
    foreach (addrs[i]) rdchk(addrs[i], rstv[i]);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      host_u.wr(wa[i], d);
      rdchk(wa[i], d & wm[i]);
    end
    // a scan with no key change goes straight back to sleep
    scan_done = 1'b1;
    @(posedge sys_clk);
    #1 scan_done = 1'b0;
    chk({15'h0000, sleep_request}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      bk = $urandom % 16;
      len = (i == 3) ? 0 : 1 + ($urandom % 8);
      host_u.wr(8'(8'h36 + bk), 8'(len));
      burst(bk, len);
    end
    host_u.wr(8'(8'h36 + K), 8'h04);
    host_u.wr(8'h12, 8'h00);
    host_u.wr(8'(8'h26 + K), 8'(th));
    host_recal = 1'b1;
    @(posedge sys_clk);
    #1 host_recal = 1'b0;
    foreach (pend[j]) pend[j] = 1'b1;
    acq(K, 1000);
    acq(K, 1000 - th);
    acq(K, 999 - th);
    acq(K, 1000);
    repeat (dil + 1) acq(K, 999 - th);
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0000, drift_frozen}, 16'h0001);
    chk({15'h0000, use_min_interval}, 16'h0001);
    acq(K, 1001 - th);
    acq(K, 1002 - th);
    chk({15'h0000, drift_frozen}, 16'h0001);
    repeat (dil + 1) acq(K, 999 - th);
    repeat (60) @(posedge sys_clk);
    #1 acq(K, 999 - th);
    acq(K, 1000);
    host_u.wr(8'h12, 8'h02);
    repeat (dil + 1) acq(K, 999 - th);
    repeat (60) @(posedge sys_clk);
    #1 pend[K] = 1'b1;
    acq(K, 999 - th);
    acq(K, 999 - th);
    // slider key 2 shares suppression group 1 with key K, which is outside the slider
    host_u.wr(8'h38, 8'h04);
    host_u.wr(8'h28, 8'(th));
    host_u.wr(8'h18, 8'h01);
    host_u.wr(8'(8'h16 + K), 8'h01);
    grp[2] = 1;
    grp[K] = 1;
    acq(2, 1000);
    repeat (dil + 1) acq(2, 999 - th);
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0000, slider_touched}, 16'h0001);
    chk({8'h00, slider_position}, 16'((2 * 255 / 4) >> 4));
    repeat (dil + 1) acq(K, 998 - 2 * th);
    conclude();
  end

  initial begin
    #1000000;
    failures++;
    conclude();
  end
endmodule
